// *** core/tccd_core.sv ***
/*
 * Connector detection and role-toggle logic: comparator sampling,
 * sticky interrupt flags with mask, open-drain interrupt pin, the
 * autonomous toggle engine and the source current advertisement.
 * Assumes control bits come from serial target logic on core_clk_i and
 * comparator outputs arrive asynchronously from the analog front end.
 */
`timescale 1ns/100ps
module tccd_core #(
   parameter int DWELL_CYCLES = tccd_pkg::TOG_DWELL_CYC
) (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   // Analog comparators, asynchronous
   input  wire logic [1:0]  cc_level_code_i,
   input  wire logic        dac_comp_i,
   input  wire logic        bus_power_valid_i,
   // Toggle control
   input  wire logic        toggle_enable_i,
   input  wire logic [1:0]  toggle_mode_i,
   // Manual termination control
   input  wire logic        cc1_pulldown_enable_i,
   input  wire logic        cc2_pulldown_enable_i,
   input  wire logic        cc1_pullup_enable_i,
   input  wire logic        cc2_pullup_enable_i,
   input  wire logic        measure_line1_select_i,
   input  wire logic        measure_line2_select_i,
   input  wire logic        measure_bus_power_select_i,
   input  wire logic        manual_attach_i,
   // Other configuration
   input  wire logic [5:0]  dac_level_i,
   input  wire logic [1:0]  source_current_advert_i,
   input  wire logic        cable_power_switch_line1_i,
   input  wire logic        cable_power_switch_line2_i,
   input  wire logic [3:0]  power_domain_enables_i,
   // Interrupt mask and clear
   input  wire logic [3:0]  irq_mask_i,
   input  wire logic [3:0]  irq_clear_i,
   // Termination outputs
   output logic             cc1_pulldown_enable_o,
   output logic             cc2_pulldown_enable_o,
   output logic             cc1_pullup_enable_o,
   output logic             cc2_pullup_enable_o,
   output logic             measure_line1_select_o,
   output logic             measure_line2_select_o,
   output logic             measure_bus_power_select_o,
   output logic [5:0]       dac_level_o,
   output logic [1:0]       pullup_current_o,
   output logic             cable_power_switch_line1_o,
   output logic             cable_power_switch_line2_o,
   output logic [3:0]       power_domain_enables_o,
   // Status
   output logic [3:0]       irq_flags_o,
   output logic [2:0]       role_search_state_o,
   output logic [1:0]       cc_level_code_o,
   output logic             bus_power_valid_o,
   // Open-drain interrupt pin
   output logic             int_n_o,
   output logic             int_n_oe_o
);

   localparam logic [tccd_pkg::DWELL_W-1:0] DWELL_LAST =
      tccd_pkg::DWELL_W'(DWELL_CYCLES - 1);

   tccd_pkg::tccd_regs_t s;
   tccd_pkg::tccd_regs_t next_s;

   logic                        dwell_end;
   logic                        attached_src;
   logic [tccd_pkg::IRQ_W-1:0]  irq_set;
   logic [tccd_pkg::IRQ_W-1:0]  flags_nx;

   //==========================================================
   // Next-state logic
   always_comb begin
      next_s    = s;
      dwell_end = (s.dwell == DWELL_LAST);
      irq_set   = '0;

      // Two-stage capture of the analog comparators
      next_s.sync1 = {bus_power_valid_i, dac_comp_i, cc_level_code_i};
      next_s.sync2 = s.sync1;
      next_s.prev  = s.sync2;

      // Any fixed-comparator change flags both level and compare
      if (s.sync2[1:0] != s.prev[1:0]) begin
         irq_set[tccd_pkg::IRQ_LVL] = 1'b1;
         irq_set[tccd_pkg::IRQ_CMP] = 1'b1;
      end
      if (s.sync2[tccd_pkg::CMP_DAC] != s.prev[tccd_pkg::CMP_DAC]) begin
         irq_set[tccd_pkg::IRQ_CMP] = 1'b1;
      end
      if (s.sync2[tccd_pkg::CMP_VB] != s.prev[tccd_pkg::CMP_VB]) begin
         irq_set[tccd_pkg::IRQ_VB] = 1'b1;
      end
      next_s.vbus_ok = s.sync2[tccd_pkg::CMP_VB];

      // 3.0 A reported as 1.5 A when the DAC at the check setting reads high
      if (s.sync2[1:0] == tccd_pkg::LVL_3A0 && s.dac == tccd_pkg::DAC_3A0_CHECK
          && s.sync2[tccd_pkg::CMP_DAC]) begin
         next_s.level = tccd_pkg::LVL_1A5;
      end else begin
         next_s.level = s.sync2[1:0];
      end

      // Toggle engine
      next_s.dwell = s.dwell + 1'b1;
      unique case (s.st)
         tccd_pkg::TS_IDLE: begin
            if (toggle_enable_i) begin
               next_s.st = (toggle_mode_i == tccd_pkg::MODE_SNK) ?
                           tccd_pkg::TS_SNK1 : tccd_pkg::TS_SRC1;
            end
         end
         tccd_pkg::TS_SRC1, tccd_pkg::TS_SRC2: begin
            // Line pulled below threshold means a sink sits on it
            if (dwell_end && !s.sync2[tccd_pkg::CMP_DAC]) begin
               next_s.st   = tccd_pkg::TS_DONE;
               next_s.role = (s.st == tccd_pkg::TS_SRC1) ?
                             tccd_pkg::ROLE_SRC_L1 : tccd_pkg::ROLE_SRC_L2;
               irq_set[tccd_pkg::IRQ_DONE] = 1'b1;
            end else if (dwell_end && s.st == tccd_pkg::TS_SRC1) begin
               next_s.st = tccd_pkg::TS_SRC2;
            end else if (dwell_end) begin
               next_s.st = (toggle_mode_i == tccd_pkg::MODE_DRP) ?
                           tccd_pkg::TS_SNK1 : tccd_pkg::TS_SRC1;
            end
         end
         tccd_pkg::TS_SNK1, tccd_pkg::TS_SNK2: begin
            // Any level above Ra means a source pull-up is present
            if (dwell_end && s.sync2[1:0] != tccd_pkg::LVL_RA) begin
               next_s.st   = tccd_pkg::TS_DONE;
               next_s.role = (s.st == tccd_pkg::TS_SNK1) ?
                             tccd_pkg::ROLE_SNK_L1 : tccd_pkg::ROLE_SNK_L2;
               irq_set[tccd_pkg::IRQ_DONE] = 1'b1;
            end else if (dwell_end && s.st == tccd_pkg::TS_SNK1) begin
               next_s.st = tccd_pkg::TS_SNK2;
            end else if (dwell_end) begin
               next_s.st = (toggle_mode_i == tccd_pkg::MODE_DRP) ?
                           tccd_pkg::TS_SRC1 : tccd_pkg::TS_SNK1;
            end
         end
         tccd_pkg::TS_DONE: begin
            next_s.st = tccd_pkg::TS_DONE;
         end
         default: begin
            next_s.st = tccd_pkg::TS_IDLE;
         end
      endcase
      if (!toggle_enable_i) begin
         next_s.st   = tccd_pkg::TS_IDLE;
         next_s.role = tccd_pkg::ROLE_NONE;
      end
      if (next_s.st != s.st) begin
         next_s.dwell = '0;
      end

      // Terminations follow the state being entered
      next_s.measure_bus_power_select = 1'b0;
      unique case (next_s.st)
         tccd_pkg::TS_SRC1: begin
            next_s.pu = 2'b01;
            next_s.pd = 2'b00;
            next_s.meas = 2'b01;
         end
         tccd_pkg::TS_SRC2: begin
            next_s.pu = 2'b10;
            next_s.pd = 2'b00;
            next_s.meas = 2'b10;
         end
         tccd_pkg::TS_SNK1: begin
            next_s.pu = 2'b00;
            next_s.pd = 2'b11;
            next_s.meas = 2'b01;
         end
         tccd_pkg::TS_SNK2: begin
            next_s.pu = 2'b00;
            next_s.pd = 2'b11;
            next_s.meas = 2'b10;
         end
         tccd_pkg::TS_DONE: begin
            // Hold the winning presentation for the final manual check
            next_s.meas = next_s.role[1:0];
            next_s.pu   = next_s.role[2] ? 2'b00 : next_s.role[1:0];
            next_s.pd   = next_s.role[2] ? 2'b11 : 2'b00;
         end
         default: begin
            next_s.pu = {cc2_pullup_enable_i, cc1_pullup_enable_i};
            next_s.pd = {cc2_pulldown_enable_i, cc1_pulldown_enable_i};
            // Routing the DAC to bus power frees both line selects
            next_s.measure_bus_power_select = measure_bus_power_select_i;
            next_s.meas = measure_bus_power_select_i ? 2'b00 :
                          {measure_line2_select_i, measure_line1_select_i};
         end
      endcase

      // Advertised current: held until a sink is seen or manual attach is set in idle, then tracks live
      attached_src = (next_s.st == tccd_pkg::TS_DONE && !next_s.role[2]) ||
                     (next_s.st == tccd_pkg::TS_IDLE && manual_attach_i);
      if (attached_src) begin
         next_s.advert = source_current_advert_i;
      end

      // Configuration taken from the serial target logic
      next_s.dac   = dac_level_i;
      next_s.vconn = {cable_power_switch_line2_i, cable_power_switch_line1_i};
      next_s.power_domain_enables   = power_domain_enables_i;

      // Set wins over a clear in the same cycle
      flags_nx         = (s.flags & ~irq_clear_i) | irq_set;
      next_s.flags     = flags_nx;
      next_s.int_drive = |(flags_nx & ~irq_mask_i);
      next_s.int_n     = !next_s.int_drive;
   end

   //==========================================================
   // State register
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         s           <= '0;
         s.st        <= tccd_pkg::TS_IDLE;
         s.int_n     <= 1'b1;
         s.advert    <= tccd_pkg::ADVERT_RESET;
      end else begin
         s <= next_s;
      end
   end

   //==========================================================
   // Outputs
   assign cc1_pulldown_enable_o      = s.pd[0];
   assign cc2_pulldown_enable_o      = s.pd[1];
   assign cc1_pullup_enable_o        = s.pu[0];
   assign cc2_pullup_enable_o        = s.pu[1];
   assign measure_line1_select_o     = s.meas[0];
   assign measure_line2_select_o     = s.meas[1];
   assign measure_bus_power_select_o = s.measure_bus_power_select;
   assign dac_level_o                = s.dac;
   assign pullup_current_o           = s.advert;
   assign cable_power_switch_line1_o = s.vconn[0];
   assign cable_power_switch_line2_o = s.vconn[1];
   assign power_domain_enables_o     = s.power_domain_enables;
   assign irq_flags_o                = s.flags;
   assign role_search_state_o        = s.role;
   assign cc_level_code_o            = s.level;
   assign bus_power_valid_o          = s.vbus_ok;
   assign int_n_o                    = s.int_n;
   assign int_n_oe_o                 = s.int_drive;

   //==========================================================
   // Assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   a_int_pin_asserts: assert property (
      (|(s.flags & ~irq_mask_i)) && irq_clear_i == '0 |=> !int_n_o && int_n_oe_o)
      else $error("interrupt pin not driven with unmasked flag pending");

   a_int_pin_release: assert property (
      !int_n_oe_o |-> int_n_o)
      else $error("interrupt pin low while released");

   a_level_change_irq: assert property (
      s.sync2[1:0] != s.prev[1:0]
      |=> s.flags[tccd_pkg::IRQ_LVL] && s.flags[tccd_pkg::IRQ_CMP])
      else $error("level change did not raise both flags");

   a_vbus_status: assert property (
      $changed(s.vbus_ok) |-> s.flags[tccd_pkg::IRQ_VB])
      else $error("bus power change without flag");

   a_done_reports_role: assert property (
      $rose(s.st == tccd_pkg::TS_DONE)
      |-> s.flags[tccd_pkg::IRQ_DONE] && s.role != tccd_pkg::ROLE_NONE)
      else $error("role settled without done flag or role");

   a_manual_idle: assert property (
      !toggle_enable_i
      |=> s.st == tccd_pkg::TS_IDLE && s.role == tccd_pkg::ROLE_NONE
          && s.pu == $past({cc2_pullup_enable_i, cc1_pullup_enable_i})
          && s.pd == $past({cc2_pulldown_enable_i, cc1_pulldown_enable_i}))
      else $error("engine kept running with toggle off");

   a_src_terms: assert property (
      s.st == tccd_pkg::TS_SRC2 |-> s.pu == 2'b10 && s.pd == 2'b00 && s.meas == 2'b10)
      else $error("source phase terminations wrong");

   a_snk_only_mode: assert property (
      toggle_enable_i && toggle_mode_i == tccd_pkg::MODE_SNK && s.st == tccd_pkg::TS_SNK2
      |=> s.st inside {tccd_pkg::TS_SNK2, tccd_pkg::TS_SNK1, tccd_pkg::TS_DONE,
                       tccd_pkg::TS_IDLE})
      else $error("sink only mode left sink phases");

   a_advert_live: assert property (
      s.st == tccd_pkg::TS_DONE && !s.role[2] && toggle_enable_i
      |=> pullup_current_o == $past(source_current_advert_i))
      else $error("advert not applied while attached");

   a_level_3a0_check: assert property (
      s.dac == tccd_pkg::DAC_3A0_CHECK && s.sync2[tccd_pkg::CMP_DAC]
      |=> cc_level_code_o != tccd_pkg::LVL_3A0)
      else $error("3.0 A reported while DAC reads 1");

   a_vbus_route: assert property (
      measure_bus_power_select_o |-> !measure_line1_select_o && !measure_line2_select_o)
      else $error("line and bus power measured together");

endmodule : tccd_core

// *** pkg/tccd_pkg.sv ***
/*
 * Constants, state encodings and the packed state record for the
 * connector detection and role-toggle block.
 * Assumes a single 10 MHz core clock and that the serial target logic
 * that holds the control bits runs on that same clock.
 */
package tccd_pkg;

   //==========================================================
   // Clock and timing
   localparam int CLK_MHZ       = 10;
   localparam int TOG_DWELL_US  = 2000;
   localparam int TOG_DWELL_CYC = TOG_DWELL_US * CLK_MHZ;
   localparam int DWELL_W       = 16;

   //==========================================================
   // Toggle modes, roles, codes
   localparam logic [1:0] MODE_DRP      = 2'h1;
   localparam logic [1:0] MODE_SRC      = 2'h2;
   localparam logic [1:0] MODE_SNK      = 2'h3;
   localparam logic [2:0] ROLE_NONE     = 3'h0;
   localparam logic [2:0] ROLE_SRC_L1   = 3'h1;
   localparam logic [2:0] ROLE_SRC_L2   = 3'h2;
   localparam logic [2:0] ROLE_SNK_L1   = 3'h5;
   localparam logic [2:0] ROLE_SNK_L2   = 3'h6;
   localparam logic [1:0] LVL_RA        = 2'h0;
   localparam logic [1:0] LVL_1A5       = 2'h2;
   localparam logic [1:0] LVL_3A0       = 2'h3;
   localparam logic [5:0] DAC_3A0_CHECK = 6'h34;
   localparam logic [1:0] ADVERT_RESET  = 2'h1;

   //==========================================================
   // Comparator sample bits and interrupt flag bits
   localparam int CMP_W  = 4;
   localparam int CMP_DAC = 2;
   localparam int CMP_VB  = 3;
   localparam int IRQ_W    = 4;
   localparam int IRQ_LVL  = 0;
   localparam int IRQ_CMP  = 1;
   localparam int IRQ_VB   = 2;
   localparam int IRQ_DONE = 3;

   //==========================================================
   // Toggle engine states, one-hot
   typedef enum logic [5:0] {
      TS_IDLE = 6'h01,
      TS_SRC1 = 6'h02,
      TS_SRC2 = 6'h04,
      TS_SNK1 = 6'h08,
      TS_SNK2 = 6'h10,
      TS_DONE = 6'h20
   } tccd_state_t;

   typedef struct packed {
      tccd_state_t          st;
      logic [DWELL_W-1:0]   dwell;
      logic [CMP_W-1:0]     sync1;
      logic [CMP_W-1:0]     sync2;
      logic [CMP_W-1:0]     prev;
      logic [IRQ_W-1:0]     flags;
      logic                 int_drive;
      logic                 int_n;
      logic [1:0]           pd;
      logic [1:0]           pu;
      logic [1:0]           meas;
      logic                 measure_bus_power_select;
      logic [5:0]           dac;
      logic [1:0]           advert;
      logic [2:0]           role;
      logic [1:0]           level;
      logic                 vbus_ok;
      logic [1:0]           vconn;
      logic [3:0]           power_domain_enables;
   } tccd_regs_t;

endpackage : tccd_pkg

// *** sim/tccd_far_end.sv ***
/*
 * Model of the party across the connector: a sink (Rd) or a source (Rp)
 * on one configuration line, seen through the analog comparators.
 * Assumes terminations come straight from the block under test.
 */
`timescale 1ns/100ps
module tccd_far_end (
   // Attached party
   input  wire logic       sink_i,
   input  wire logic       src_i,
   input  wire logic       line2_i,
   input  wire logic [1:0] adv_i,
   // Terminations from the block
   input  wire logic [1:0] pu_i,
   input  wire logic [1:0] pd_i,
   input  wire logic [1:0] meas_i,
   // Comparator results
   output logic [1:0]      level_o,
   output logic            dac_o,
   output logic            vbus_o
);
   logic [1:0] on;
   assign on = line2_i ? 2'h2 : 2'h1;
   // Rd drags a pulled-up line under the threshold; an unpulled line sits low unless a far-end source is on it
   assign dac_o = |(meas_i & pu_i & ~(sink_i ? on : 2'h0)) | (src_i & |(meas_i & on));
   assign level_o = (src_i && |(meas_i & pd_i & on)) ? adv_i : 2'h0;
   assign vbus_o = src_i;
endmodule : tccd_far_end

// *** sim/tb.sv ***
/*
 * Self-checking bench for the detection and toggle block.
 * Assumes the far-end model above; comparators are fed by it or by the bench.
 */
`timescale 1ns/100ps
module tb;
   typedef struct packed {logic [3:0] s; logic [7:0] v;} tccd_exp_t;
   logic       core_clk_i = 1'b0, nrst_i = 1'b0, use_far = 1'b0, ten = 1'b0, att = 1'b0;
   logic       dac_tb = 1'b0, vb_tb = 1'b0, sink = 1'b0, src = 1'b0, l2 = 1'b0;
   logic [1:0] lvl_tb = 2'h0, mode = 2'h1, adv = 2'h1, vc = 2'h0, lvl_far;
   logic [6:0] man = 7'h0;
   logic [5:0] dac = 6'h0, dac_o;
   logic [3:0] power_domain_enables = 4'h0, mask = 4'h0, clr = 4'h0, pwr_o, flags;
   logic       pd1, pd2, pu1, pu2, m1, m2, mv, vc1, vc2, vb_o, int_n, int_oe, dac_far, vb_far;
   logic [1:0] cur, lvl_o;
   logic [2:0] role;
   int         n_fail = 0, checked = 0;
   tccd_exp_t  expq[$];
   tccd_exp_t  e;
   event       look_ev;
   wire        int_line = ~(int_oe & ~int_n);
   logic [1:0] md [3] = '{tccd_pkg::MODE_DRP, tccd_pkg::MODE_SRC, tccd_pkg::MODE_SNK};
   logic [2:0] rl [3] = '{tccd_pkg::ROLE_SRC_L2, tccd_pkg::ROLE_SRC_L1, tccd_pkg::ROLE_SNK_L2};
   logic [7:0] tm [3] = '{8'h28, 8'h14, 8'h23};

   initial forever #50 core_clk_i = ~core_clk_i;

   //==========================================================
   // Design and far end
   tccd_core #(.DWELL_CYCLES(8)) i_tccd_core (
      .core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .cc_level_code_i(use_far ? lvl_far : lvl_tb), .dac_comp_i(use_far ? dac_far : dac_tb),
      .bus_power_valid_i(use_far ? vb_far : vb_tb),
      .toggle_enable_i(ten), .toggle_mode_i(mode),
      .cc1_pulldown_enable_i(man[0]), .cc2_pulldown_enable_i(man[1]),
      .cc1_pullup_enable_i(man[2]), .cc2_pullup_enable_i(man[3]),
      .measure_line1_select_i(man[4]), .measure_line2_select_i(man[5]),
      .measure_bus_power_select_i(man[6]), .manual_attach_i(att),
      .dac_level_i(dac), .source_current_advert_i(adv),
      .cable_power_switch_line1_i(vc[0]), .cable_power_switch_line2_i(vc[1]),
      .power_domain_enables_i(power_domain_enables), .irq_mask_i(mask), .irq_clear_i(clr),
      .cc1_pulldown_enable_o(pd1), .cc2_pulldown_enable_o(pd2),
      .cc1_pullup_enable_o(pu1), .cc2_pullup_enable_o(pu2),
      .measure_line1_select_o(m1), .measure_line2_select_o(m2),
      .measure_bus_power_select_o(mv), .dac_level_o(dac_o), .pullup_current_o(cur),
      .cable_power_switch_line1_o(vc1), .cable_power_switch_line2_o(vc2),
      .power_domain_enables_o(pwr_o), .irq_flags_o(flags), .role_search_state_o(role),
      .cc_level_code_o(lvl_o), .bus_power_valid_o(vb_o), .int_n_o(int_n), .int_n_oe_o(int_oe));

   tccd_far_end i_tccd_far_end (
      .sink_i(sink), .src_i(src), .line2_i(l2), .adv_i(2'h2),
      .pu_i({pu2, pu1}), .pd_i({pd2, pd1}), .meas_i({m2, m1}),
      .level_o(lvl_far), .dac_o(dac_far), .vbus_o(vb_far));

   //==========================================================
   // Checking
   function automatic logic [7:0] obs(input logic [3:0] s);
      case (s)
         4'h0: obs = {4'h0, flags};
         4'h1: obs = {5'h0, role};
         4'h2: obs = {6'h0, lvl_o};
         4'h3: obs = {7'h0, vb_o};
         4'h4: obs = {7'h0, int_line};
         4'h5: obs = {2'h0, m2, m1, pu2, pu1, pd2, pd1};
         4'h6: obs = {6'h0, cur};
         4'h7: obs = {2'h0, dac_o};
         4'h9: obs = {7'h0, flags[2]};
         4'ha: obs = {7'h0, flags[3]};
         default: obs = {1'b0, mv, vc2, vc1, pwr_o};
      endcase
   endfunction : obs

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   // Results are looked at whenever the driver steps the clock
   always @(look_ev) begin
      while (expq.size() > 0) begin
         e = expq.pop_front();
         check(obs(e.s), e.v);
      end
   end

   task automatic note(input logic [3:0] s, input logic [7:0] v);
      expq.push_back('{s, v});
   endtask : note

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   task automatic cyc(input int n);
      -> look_ev;
      #1;
      repeat (n) @(negedge core_clk_i);
   endtask : cyc

   task automatic pulse(input logic [3:0] c);
      clr = c;
      cyc(1);
      clr = 4'h0;
   endtask : pulse

   task automatic wait_done();
      int k;
      k = 0;
      while (flags[3] !== 1'b1 && k < 200) begin
         cyc(1);
         k++;
      end
      if (flags[3] !== 1'b1) begin
         n_fail++;
         stop_test();
      end
   endtask : wait_done

   //==========================================================
   // Stimulus
   initial begin
      void'($urandom(36492));
      cyc(5);
      note(4'h4, 8'h01);
      note(4'h6, {6'h0, tccd_pkg::ADVERT_RESET});
      note(4'h0, 8'h00);
      cyc(1);
      nrst_i = 1'b1;
      cyc(3);
      // Level change: both flags exactly three edges on, then clear and mask
      lvl_tb = 2'h1;
      cyc(2);
      note(4'h0, 8'h00);
      cyc(1);
      note(4'h0, 8'h03);
      note(4'h4, 8'h00);
      note(4'h2, 8'h01);
      pulse(4'h1);
      note(4'h0, 8'h02);
      note(4'h4, 8'h00);
      pulse(4'h2);
      note(4'h4, 8'h01);
      mask = 4'hf;
      lvl_tb = 2'h2;
      cyc(3);
      note(4'h0, 8'h03);
      note(4'h4, 8'h01);
      mask = 4'h0;
      cyc(1);
      note(4'h4, 8'h00);
      pulse(4'h3);
      note(4'h4, 8'h01);
      // At the DAC check setting the top level code only stands while the fine compare reads low
      dac = 6'h34;
      dac_tb = 1'b1;
      lvl_tb = 2'h3;
      cyc(3);
      note(4'h2, 8'h02);
      note(4'h7, 8'h34);
      dac_tb = 1'b0;
      cyc(3);
      note(4'h2, 8'h03);
      pulse(4'hf);
      vb_tb = 1'b1;
      cyc(3);
      note(4'h9, 8'h01);
      note(4'h3, 8'h01);
      pulse(4'hf);
      vb_tb = 1'b0;
      cyc(3);
      note(4'h9, 8'h01);
      note(4'h3, 8'h00);
      pulse(4'hf);
      // Manual controls and configuration with random values
      for (int i = 0; i < 4; i++) begin
         man = 7'($urandom);
         dac = 6'($urandom);
         power_domain_enables = 4'($urandom);
         vc = 2'($urandom);
         adv = 2'($urandom);
         cyc(1);
         note(4'h5, {2'h0, (man[6] ? 2'h0 : man[5:4]), man[3:0]});
         note(4'h7, {2'h0, dac});
         note(4'h8, {1'b0, man[6], vc, power_domain_enables});
         note(4'h6, 8'h01);
      end
      man = 7'h0;
      vc = 2'h0;
      adv = 2'h3;
      att = 1'b1;
      cyc(1);
      note(4'h6, 8'h03);
      adv = 2'h2;
      cyc(1);
      note(4'h6, 8'h02);
      att = 1'b0;
      adv = 2'h1;
      cyc(1);
      note(4'h6, 8'h02);
      // Autonomous search in every mode against the far-end model
      power_domain_enables = 4'h1;
      mask = 4'h6;
      use_far = 1'b1;
      for (int k = 0; k < 3; k++) begin
         mode = md[k];
         sink = (k < 2);
         src = (k == 2);
         l2 = (k != 1);
         cyc(3);
         pulse(4'hf);
         ten = 1'b1;
         wait_done();
         note(4'h1, {5'h0, rl[k]});
         note(4'h5, tm[k]);
         note(4'ha, 8'h01);
         note(4'h4, 8'h00);
         if (k < 2) begin
            adv = 2'h3;
            cyc(1);
            note(4'h6, 8'h03);
         end else begin
            note(4'h2, 8'h02);
         end
         ten = 1'b0;
         adv = 2'h1;
         cyc(1);
         note(4'h1, 8'h00);
         note(4'h5, 8'h00);
         sink = 1'b0;
         src = 1'b0;
      end
      cyc(1);
      stop_test();
   end
endmodule : tb
